/* src/sepc_pkg.sv */
// shared constants and carrier types of the sector erase and protection control block
// Notes on behaviour
// RQ1: a failed internal program or erase sets its error bit; operation counts as not done.
// RQ2: program or erase on a protected sector leaves it untouched and sets the error bit.
// RQ3: while the freeze bit is set, block protection bits cannot change.
// RQ4: freeze also holds parameter placement bit, protect origin bit and the OTP region.
// RQ5: sixteen 4 kbyte parameter sectors sit at top or bottom of the address space.
// RQ6: second status register bit 7 drops the parameter sectors, leaving uniform sectors.
// RQ7: no command erases an 8 kbyte pair of parameter sectors.
// RQ8: the 4 kbyte erase acts only on the parameter sectors.
// RQ9: in 64 kbyte mode the 64 kbyte erase works, also on the parameter group.
// RQ10: in 256 kbyte mode the large erase command erases 256 kbyte sectors.
// RQ11: no deep power down; opcode b9 reaches the bank address register.
// RQ12: bank address register bits extend every command address above 24 bits.
// RQ13: an option turns quad line three into a hardware reset input instead of hold.
// RQ14: one command per chip select low interval, with instruction, address and data.
// RQ15: the host sends an 8 bit instruction first in every command.
// RQ16: error bits stay set until the host clears them explicitly.
package sepc_pkg;
    localparam int ADDR_BYTES = 3;
    localparam int FULL_AW = 32;
    localparam int ARRAY_AW = 24;

    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_8K = 8'h40;
    localparam logic [7:0] OP_ERASE_BIG = 8'hd8;
    localparam logic [7:0] OP_BANK_WRITE = 8'hb9;
    localparam logic [7:0] OP_WRITE_REGS = 8'h01;
    localparam logic [7:0] OP_READ_SR1 = 8'h05;
    localparam logic [7:0] OP_READ_SR2 = 8'h07;
    localparam logic [7:0] OP_READ_CFG = 8'h35;
    localparam logic [7:0] OP_READ_BANK = 8'h16;
    localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;

    localparam int SR1_BUSY = 0;
    localparam int SR1_BP_LO = 2;
    localparam int SR1_BP_HI = 4;
    localparam int SR1_E_ERR = 5;
    localparam int SR1_P_ERR = 6;
    localparam int CFG_FREEZE = 0;
    localparam int CFG_PARAM_PLACE = 2;
    localparam int CFG_PROT_ORIGIN = 5;
    localparam int SR2_UNIFORM = 7;
    localparam logic [7:0] CFG_FROZEN_MASK = 8'h25;

    localparam logic [7:0] SR1_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] BANK_RESET = 8'h00;

    localparam int PARAM_SECTORS = 16;
    localparam int SECTOR_4K_BITS = 12;
    localparam int SECTOR_64K_BITS = 16;
    localparam int SECTOR_256K_BITS = 18;

    typedef enum logic [1:0] {
        SEPC_KIND_PROGRAM,
        SEPC_KIND_ERASE_4K,
        SEPC_KIND_ERASE_64K,
        SEPC_KIND_ERASE_256K
    } sepc_kind_e;

    typedef struct packed {
        logic vld;
        logic [7:0] data;
    } sepc_byte_s;

    typedef struct packed {
        logic req;
        sepc_kind_e kind;
        logic [FULL_AW-1:0] addr;
    } sepc_op_s;
endpackage

/* src/sepc_link.sv */
// pin synchronisers, serial shifter and framing of the command link
`timescale 1ns/1ps
`default_nettype none
module sepc_link
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic quad_line_three,
    input wire logic line_three_is_reset,
    input wire logic [7:0] tx_byte,
    output sepc_pkg::sepc_byte_s rx,
    output logic frame_end,
    output logic frame_on,
    output logic hw_reset,
    output logic so,
    output logic so_oe,
    input wire logic so_enable
);
    import sepc_pkg::*;

    logic [2:0] s1_ff, s2_ff, s3_ff, lvl_ff;
    logic [2:0] nxt_lvl;
    logic [2:0] sh_ff, nxt_sh;
    logic [2:0] sd_ff, nxt_sd;
    logic [3:0] nxt_l3_sh, l3_ff;
    logic [7:0] rxs_ff, nxt_rxs;
    logic [2:0] cnt_ff, nxt_cnt;
    logic [7:0] txs_ff, nxt_txs;
    logic so_ff, nxt_so;
    logic soe_ff, nxt_soe;
    sepc_byte_s rx_ff, nxt_rx;
    logic fend_ff, nxt_fend;
    logic hold_ok, l3_lvl, sck_rise, sck_fall, cs_low;

    // three stage sync of cs_n, sck and si; a level counts once stages two and three agree
    always_comb
    begin
        nxt_sh = s1_ff;
        nxt_sd = s2_ff;
        nxt_l3_sh = {l3_ff[2:0], quad_line_three};
        nxt_lvl = lvl_ff;
        for (int i = 0; i < 3; i++)
        begin
            if (s2_ff[i] == s3_ff[i])
            begin
                nxt_lvl[i] = s3_ff[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_ff <= 3'h1;
            s2_ff <= 3'h1;
            s3_ff <= 3'h1;
            lvl_ff <= 3'h1;
            l3_ff <= 4'hf;
        end
        else
        begin
            s1_ff <= {si, sck, cs_n};
            s2_ff <= nxt_sh;
            s3_ff <= nxt_sd;
            lvl_ff <= nxt_lvl;
            l3_ff <= nxt_l3_sh;
        end
    end

    assign l3_lvl = (l3_ff[2] == l3_ff[3]) ? l3_ff[3] : 1'b1;
    assign hw_reset = line_three_is_reset & (l3_ff[2] == l3_ff[3]) & ~l3_ff[3]; // RQ13
    assign hold_ok = line_three_is_reset | l3_lvl; // RQ13
    assign cs_low = ~lvl_ff[0];
    assign sck_rise = nxt_lvl[1] & ~lvl_ff[1] & hold_ok;
    assign sck_fall = ~nxt_lvl[1] & lvl_ff[1] & hold_ok;

    always_comb
    begin
        nxt_rxs = rxs_ff;
        nxt_cnt = cnt_ff;
        nxt_txs = txs_ff;
        nxt_so = so_ff;
        nxt_soe = soe_ff & cs_low & so_enable;
        nxt_rx = '0;
        nxt_fend = 1'b0;
        if (!cs_low)
        begin
            nxt_cnt = 3'h0;
            nxt_soe = 1'b0;
            nxt_fend = frame_on; // RQ14
        end
        else
        begin
            if (sck_rise)
            begin
                nxt_rxs = {rxs_ff[6:0], lvl_ff[2]}; // RQ15
                nxt_cnt = cnt_ff + 3'h1;
                if (cnt_ff == 3'h7)
                begin
                    nxt_rx.vld = 1'b1;
                    nxt_rx.data = {rxs_ff[6:0], lvl_ff[2]};
                end
            end
            if (sck_fall && so_enable)
            begin
                nxt_soe = 1'b1;
                if (cnt_ff == 3'h0)
                begin
                    nxt_so = tx_byte[7];
                    nxt_txs = {tx_byte[6:0], 1'b0};
                end
                else
                begin
                    nxt_so = txs_ff[7];
                    nxt_txs = {txs_ff[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rxs_ff <= 8'h00;
            cnt_ff <= 3'h0;
            txs_ff <= 8'h00;
            so_ff <= 1'b0;
            soe_ff <= 1'b0;
            rx_ff <= '0;
            fend_ff <= 1'b0;
            frame_on <= 1'b0;
        end
        else
        begin
            rxs_ff <= nxt_rxs;
            cnt_ff <= nxt_cnt;
            txs_ff <= nxt_txs;
            so_ff <= nxt_so;
            soe_ff <= nxt_soe;
            rx_ff <= nxt_rx;
            fend_ff <= nxt_fend;
            frame_on <= cs_low;
        end
    end

    assign rx = rx_ff;
    assign frame_end = fend_ff;
    assign so = so_ff;
    assign so_oe = soe_ff;
endmodule
`default_nettype wire

/* src/sepc_map.sv */
// sector map: erase legality and protected range check for one address
`timescale 1ns/1ps
`default_nettype none
module sepc_map
(
    input wire logic [sepc_pkg::ARRAY_AW-1:0] addr,
    input wire sepc_pkg::sepc_kind_e kind,
    input wire logic [2:0] bp,
    input wire logic param_top,
    input wire logic prot_bottom,
    input wire logic uniform_256k,
    output logic legal,
    output logic is_protected
);
    import sepc_pkg::*;

    logic in_top64, in_bot64, in_param;
    logic [ARRAY_AW-1:0] span_mask;

    assign in_top64 = &addr[ARRAY_AW-1:SECTOR_64K_BITS];
    assign in_bot64 = ~|addr[ARRAY_AW-1:SECTOR_64K_BITS];
    // sixteen 4k sectors fill one 64k group at top or bottom
    assign in_param = ~uniform_256k & (param_top ? in_top64 : in_bot64); // RQ5 RQ6

    always_comb
    begin
        case (kind)
            SEPC_KIND_PROGRAM: legal = 1'b1;
            SEPC_KIND_ERASE_4K: legal = in_param; // RQ8
            SEPC_KIND_ERASE_64K: legal = ~uniform_256k; // RQ9
            SEPC_KIND_ERASE_256K: legal = uniform_256k; // RQ10
            default: legal = 1'b0;
        endcase
    end

    // bp = n (1 to 6) protects the top or bottom 1/2^(7-n) of the array, 0 protects none, 7 protects all
    always_comb
    begin
        span_mask = {ARRAY_AW{1'b1}} >> (3'h7 - bp);
        if (bp == 3'h0)
        begin
            is_protected = 1'b0;
        end
        else if (bp == 3'h7)
        begin
            is_protected = 1'b1;
        end
        else if (prot_bottom)
        begin
            is_protected = (addr & ~span_mask) == '0;
        end
        else
        begin
            is_protected = (addr | span_mask) == {ARRAY_AW{1'b1}};
        end
    end
endmodule
`default_nettype wire

/* src/sepc_top.sv */
// command decoder, status and configuration registers of the sector erase and protection control
`timescale 1ns/1ps
`default_nettype none
module sepc_top
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic quad_line_three,
    input wire logic line_three_is_reset,
    input wire logic uniform_256k,
    output sepc_pkg::sepc_op_s op,
    input wire logic op_done,
    input wire logic op_fail,
    output logic [7:0] status_reg,
    output logic [7:0] first_config_register,
    output logic [7:0] second_status_register,
    output logic [7:0] bank_reg,
    output logic otp_locked
);
    import sepc_pkg::*;

    typedef enum logic [2:0] {
        SEPC_ST_OPCODE,
        SEPC_ST_ADDR,
        SEPC_ST_DATA,
        SEPC_ST_READ,
        SEPC_ST_SKIP
    } sepc_state_e;

    sepc_byte_s rx;
    logic frame_end, frame_on, hw_reset;
    logic map_legal, map_prot;
    sepc_kind_e cand_kind;

    sepc_state_e st_ff, nxt_st;
    logic [7:0] opc_ff, nxt_opc;
    logic [1:0] acnt_ff, nxt_acnt;
    logic [ARRAY_AW-1:0] addr_ff, nxt_addr;
    logic [1:0] dcnt_ff, nxt_dcnt;
    logic [7:0] d0_ff, nxt_d0;
    logic [7:0] d1_ff, nxt_d1;
    logic [7:0] tx_ff, nxt_tx;

    logic [7:0] sr1_ff, nxt_sr1;
    logic [7:0] cfg_ff, nxt_cfg;
    logic [7:0] bank_ff, nxt_bank;
    logic busy_ff, nxt_busy;
    logic busy_prog_ff, nxt_busy_prog;
    sepc_op_s op_ff, nxt_op;
    logic is_array_op, is_read;

    sepc_link u_link
    (
        .mclk(mclk),
        .nrst(nrst),
        .cs_n(cs_n),
        .sck(sck),
        .si(si),
        .quad_line_three(quad_line_three),
        .line_three_is_reset(line_three_is_reset),
        .tx_byte(tx_ff),
        .rx(rx),
        .frame_end(frame_end),
        .frame_on(frame_on),
        .hw_reset(hw_reset),
        .so(so),
        .so_oe(so_oe),
        .so_enable(st_ff == SEPC_ST_READ)
    );

    always_comb
    begin
        case (opc_ff)
            OP_ERASE_4K: cand_kind = SEPC_KIND_ERASE_4K;
            OP_ERASE_BIG: cand_kind = uniform_256k ? SEPC_KIND_ERASE_256K : SEPC_KIND_ERASE_64K; // RQ10
            default: cand_kind = SEPC_KIND_PROGRAM;
        endcase
    end

    sepc_map u_map
    (
        .addr(addr_ff),
        .kind(cand_kind),
        .bp(sr1_ff[SR1_BP_HI:SR1_BP_LO]),
        .param_top(cfg_ff[CFG_PARAM_PLACE]),
        .prot_bottom(cfg_ff[CFG_PROT_ORIGIN]),
        .uniform_256k(uniform_256k),
        .legal(map_legal),
        .is_protected(map_prot)
    );

    // 8k pair erase opcode is simply not decoded
    assign is_array_op = (opc_ff == OP_PROGRAM) | (opc_ff == OP_ERASE_4K) | (opc_ff == OP_ERASE_BIG); // RQ7
    assign is_read = (opc_ff == OP_READ_SR1) | (opc_ff == OP_READ_SR2) |
                     (opc_ff == OP_READ_CFG) | (opc_ff == OP_READ_BANK);

    // command framing
    always_comb
    begin
        nxt_st = st_ff;
        nxt_opc = opc_ff;
        nxt_acnt = acnt_ff;
        nxt_addr = addr_ff;
        nxt_dcnt = dcnt_ff;
        nxt_d0 = d0_ff;
        nxt_d1 = d1_ff;
        nxt_tx = tx_ff;
        if (!frame_on)
        begin
            nxt_st = SEPC_ST_OPCODE; // RQ14
            nxt_acnt = 2'h0;
            nxt_dcnt = 2'h0;
        end
        else if (rx.vld)
        begin
            case (st_ff)
                SEPC_ST_OPCODE:
                begin
                    nxt_opc = rx.data; // RQ15
                    case (rx.data)
                        OP_PROGRAM, OP_ERASE_4K, OP_ERASE_BIG: nxt_st = SEPC_ST_ADDR;
                        OP_WRITE_REGS, OP_BANK_WRITE: nxt_st = SEPC_ST_DATA; // RQ11
                        OP_READ_SR1: nxt_st = SEPC_ST_READ;
                        OP_READ_SR2: nxt_st = SEPC_ST_READ;
                        OP_READ_CFG: nxt_st = SEPC_ST_READ;
                        OP_READ_BANK: nxt_st = SEPC_ST_READ;
                        default: nxt_st = SEPC_ST_SKIP;
                    endcase
                end
                SEPC_ST_ADDR:
                begin
                    nxt_addr = {addr_ff[ARRAY_AW-9:0], rx.data};
                    nxt_acnt = acnt_ff + 2'h1;
                    if (acnt_ff == 2'(ADDR_BYTES - 1))
                    begin
                        nxt_st = SEPC_ST_SKIP;
                    end
                end
                SEPC_ST_DATA:
                begin
                    if (dcnt_ff == 2'h0)
                    begin
                        nxt_d0 = rx.data;
                    end
                    else
                    begin
                        nxt_d1 = rx.data;
                    end
                    if (dcnt_ff != 2'h2)
                    begin
                        nxt_dcnt = dcnt_ff + 2'h1;
                    end
                end
                SEPC_ST_READ: nxt_st = SEPC_ST_READ;
                SEPC_ST_SKIP: nxt_st = SEPC_ST_SKIP;
                default: nxt_st = SEPC_ST_SKIP;
            endcase
        end
        case (opc_ff)
            OP_READ_SR2: nxt_tx = second_status_register;
            OP_READ_CFG: nxt_tx = cfg_ff;
            OP_READ_BANK: nxt_tx = bank_ff;
            default: nxt_tx = status_reg;
        endcase
        if (!is_read)
        begin
            nxt_tx = status_reg;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_ff <= SEPC_ST_OPCODE;
            opc_ff <= 8'h00;
            acnt_ff <= 2'h0;
            addr_ff <= '0;
            dcnt_ff <= 2'h0;
            d0_ff <= 8'h00;
            d1_ff <= 8'h00;
            tx_ff <= 8'h00;
        end
        else
        begin
            st_ff <= nxt_st;
            opc_ff <= nxt_opc;
            acnt_ff <= nxt_acnt;
            addr_ff <= nxt_addr;
            dcnt_ff <= nxt_dcnt;
            d0_ff <= nxt_d0;
            d1_ff <= nxt_d1;
            tx_ff <= nxt_tx;
        end
    end

    // registers and array operations, acting at the end of each frame that ends while not busy, and on op_done
    always_comb
    begin
        nxt_sr1 = sr1_ff;
        nxt_cfg = cfg_ff;
        nxt_bank = bank_ff;
        nxt_busy = busy_ff;
        nxt_busy_prog = busy_prog_ff;
        nxt_op = op_ff;
        nxt_op.req = 1'b0;
        if (frame_end && !busy_ff)
        begin
            if (opc_ff == OP_CLEAR_STATUS)
            begin
                nxt_sr1[SR1_E_ERR] = 1'b0; // RQ16
                nxt_sr1[SR1_P_ERR] = 1'b0; // RQ16
            end
            if ((opc_ff == OP_BANK_WRITE) && (dcnt_ff != 2'h0))
            begin
                nxt_bank = d0_ff; // RQ11 RQ12
            end
            if ((opc_ff == OP_WRITE_REGS) && (dcnt_ff != 2'h0))
            begin
                if (!cfg_ff[CFG_FREEZE])
                begin
                    nxt_sr1[SR1_BP_HI:SR1_BP_LO] = d0_ff[SR1_BP_HI:SR1_BP_LO]; // RQ3
                end
                if (dcnt_ff == 2'h2)
                begin
                    // frozen fields keep their value; freeze itself only leaves on reset
                    nxt_cfg = cfg_ff[CFG_FREEZE] ? ((d1_ff & ~CFG_FROZEN_MASK) | (cfg_ff & CFG_FROZEN_MASK))
                                                  : (d1_ff | (cfg_ff & 8'h01)); // RQ4
                end
            end
            if (is_array_op && (acnt_ff == 2'(ADDR_BYTES)) && map_legal)
            begin
                if (map_prot)
                begin
                    if (opc_ff == OP_PROGRAM)
                    begin
                        nxt_sr1[SR1_P_ERR] = 1'b1; // RQ2
                    end
                    else
                    begin
                        nxt_sr1[SR1_E_ERR] = 1'b1; // RQ2
                    end
                end
                else
                begin
                    nxt_op.req = 1'b1;
                    nxt_op.kind = cand_kind; // RQ8 RQ9 RQ10
                    nxt_op.addr = {bank_ff, addr_ff}; // RQ12
                    nxt_busy = 1'b1;
                    nxt_busy_prog = (opc_ff == OP_PROGRAM);
                end
            end
        end
        if (busy_ff && op_done)
        begin
            nxt_busy = 1'b0;
            if (op_fail)
            begin
                // a set here lands after any clear, so it wins
                if (busy_prog_ff)
                begin
                    nxt_sr1[SR1_P_ERR] = 1'b1; // RQ1
                end
                else
                begin
                    nxt_sr1[SR1_E_ERR] = 1'b1; // RQ1
                end
            end
        end
        nxt_sr1[SR1_BUSY] = nxt_busy;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sr1_ff <= SR1_RESET;
            cfg_ff <= CFG_RESET;
            bank_ff <= BANK_RESET;
            busy_ff <= 1'b0;
            busy_prog_ff <= 1'b0;
            op_ff <= '0;
        end
        else if (hw_reset)
        begin
            sr1_ff <= SR1_RESET; // RQ13
            cfg_ff <= CFG_RESET;
            bank_ff <= BANK_RESET;
            busy_ff <= 1'b0;
            busy_prog_ff <= 1'b0;
            op_ff <= '0;
        end
        else
        begin
            sr1_ff <= nxt_sr1;
            cfg_ff <= nxt_cfg;
            bank_ff <= nxt_bank;
            busy_ff <= nxt_busy;
            busy_prog_ff <= nxt_busy_prog;
            op_ff <= nxt_op;
        end
    end

    assign op = op_ff;
    assign status_reg = sr1_ff;
    assign first_config_register = cfg_ff;
    assign second_status_register = {uniform_256k, 7'h00}; // RQ6
    assign bank_reg = bank_ff;
    assign otp_locked = cfg_ff[CFG_FREEZE]; // RQ4
endmodule
`default_nettype wire

/* sim/sepc_chk.sv */
// port assertions of the sector erase and protection control block
`timescale 1ns/1ps
`default_nettype none
module sepc_chk
import sepc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic line_three_is_reset,
    input wire logic uniform_256k,
    input wire sepc_pkg::sepc_op_s op,
    input wire logic op_done,
    input wire logic op_fail,
    input wire logic [7:0] status_reg,
    input wire logic [7:0] first_config_register,
    input wire logic [7:0] second_status_register,
    input wire logic [7:0] bank_reg,
    input wire logic otp_locked
);
    // kind of the operation in flight, picks which error bit a failure sets
    logic prog_ff;
    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            prog_ff <= 1'b0;
        else if (op.req)
            prog_ff <= (op.kind == SEPC_KIND_PROGRAM);

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_req_single_pulse: assert property (op.req |=> !op.req) else $error("op request longer than one cycle");
    a_req_not_busy: assert property (op.req |-> !$past(status_reg[SR1_BUSY])) else $error("request while busy");
    a_bank_extends_addr: assert property (op.req |-> op.addr[31:24] == bank_reg)
        else $error("bank bits missing from address");
    a_small_erase_param: assert property (op.req && op.kind == SEPC_KIND_ERASE_4K |-> !uniform_256k &&
        op.addr[23:16] == (first_config_register[CFG_PARAM_PLACE] ? 8'hff : 8'h00))
        else $error("small erase outside parameter group");
    a_big_erase_mode: assert property (op.req && op.kind inside {SEPC_KIND_ERASE_64K, SEPC_KIND_ERASE_256K}
        |-> uniform_256k == (op.kind == SEPC_KIND_ERASE_256K)) else $error("large erase kind wrong for mode");
    a_fail_sets_err: assert property (op_done && op_fail && status_reg[SR1_BUSY]
        |=> status_reg[prog_ff ? SR1_P_ERR : SR1_E_ERR]) else $error("failure not reported");
    a_err_held_set: assert property ($fell(status_reg[SR1_E_ERR]) |-> line_three_is_reset || (cs_n && $past(cs_n, 3)))
        else $error("erase error dropped without clear command");
    a_freeze_cfg: assert property (first_config_register[CFG_FREEZE] && !line_three_is_reset
        |=> (first_config_register & CFG_FROZEN_MASK) == ($past(first_config_register) & CFG_FROZEN_MASK))
        else $error("frozen config bits changed");
    a_freeze_bp: assert property (first_config_register[CFG_FREEZE] && !line_three_is_reset |=> $stable(status_reg[4:2]))
        else $error("protect bits changed while frozen");
    a_otp_follows: assert property (otp_locked == first_config_register[CFG_FREEZE]) else $error("otp lock mismatch");
    a_sr2_mode: assert property ($stable(uniform_256k)[*3] |-> second_status_register == {uniform_256k, 7'h00})
        else $error("second status register wrong");
endmodule
`default_nettype wire

/* sim/sepc_host.sv */
// serial host model issuing commands framed by chip select
`timescale 1ns/1ps
`default_nettype none
module sepc_host
(
    input wire logic mclk,
    input wire logic so,
    output var logic cs_n,
    output var logic sck,
    output var logic si
);
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // n bytes of w sent msb first in one frame; rd holds the last byte read
    task automatic xfer(input logic [31:0] w, input int n, output logic [7:0] rd);
        @(posedge mclk);
        cs_n <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 8 * n; i++)
        begin
            si <= w[31 - i];
            repeat (5) @(posedge mclk);
            sck <= 1'b1;
            rd = {rd[6:0], so};
            repeat (5) @(posedge mclk);
            sck <= 1'b0;
        end
        repeat (5) @(posedge mclk);
        cs_n <= 1'b1;
        si <= ~si;
    endtask
endmodule
`default_nettype wire

/* sim/sepc_tb_top.sv */
// self-checking testbench of the sector erase and protection control block
`timescale 1ns/1ps
`default_nettype none
module sepc_tb_top;
    import sepc_pkg::*;
    logic mclk, nrst, so, so_oe, quad_line_three, line_three_is_reset, uniform_256k;
    logic op_done, op_fail, otp_locked, cs_n, sck, si;
    sepc_op_s op, last_op;
    logic [7:0] status_reg, first_config_register, second_status_register, bank_reg, v;
    int error_cnt = 0;
    int cmp_count = 0;
    int req_cnt = 0;
    int eng_cnt = 0;
    int cyc = 0;
    int n;

    sepc_top DUT (.mclk(mclk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe),
        .quad_line_three(quad_line_three), .line_three_is_reset(line_three_is_reset),
        .uniform_256k(uniform_256k), .op(op), .op_done(op_done), .op_fail(op_fail), .status_reg(status_reg),
        .first_config_register(first_config_register), .second_status_register(second_status_register),
        .bank_reg(bank_reg), .otp_locked(otp_locked));
    sepc_host host (.mclk(mclk), .so(so), .cs_n(cs_n), .sck(sck), .si(si));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // array engine: answers each request three cycles later
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            test_done();
        end
        op_done <= 1'b0;
        if (op.req === 1'b1)
        begin
            req_cnt++;
            last_op <= op;
            eng_cnt <= 3;
        end
        else if (eng_cnt == 1)
        begin
            op_done <= 1'b1;
            eng_cnt <= 0;
        end
        else if (eng_cnt != 0)
            eng_cnt <= eng_cnt - 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [31:0] w, input int nb);
        logic [7:0] rd;
        host.xfer(w, nb, rd);
        repeat (16) @(posedge mclk);
    endtask

    task automatic rdreg(input logic [7:0] opc, output logic [7:0] val);
        host.xfer({opc, 24'h000000}, 2, val);
        repeat (16) @(posedge mclk);
    endtask

    task automatic chk_op(input int n0, input sepc_kind_e k, input logic [31:0] a);
        chk(req_cnt, n0 + 1);
        chk(last_op.kind, k);
        chk(last_op.addr, a);
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        nrst = 1'b0;
        quad_line_three = 1'b1;
        line_three_is_reset = 1'b0;
        uniform_256k = 1'b0;
        op_fail = 1'b0;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        chk({status_reg, first_config_register, bank_reg}, 32'h0);
        cmd({OP_BANK_WRITE, 8'h01, 16'h0000}, 2);
        chk(bank_reg, 8'h01);
        rdreg(OP_READ_BANK, v);
        chk(v, 8'h01);
        n = req_cnt;
        cmd({OP_PROGRAM, 24'h001000}, 4);
        chk_op(n, SEPC_KIND_PROGRAM, 32'h01001000);
        cmd({OP_BANK_WRITE, 8'h00, 16'h0000}, 2);
        n = req_cnt;
        cmd({OP_ERASE_4K, 24'h00f000}, 4);
        chk_op(n, SEPC_KIND_ERASE_4K, 32'h0000f000);
        n = req_cnt;
        cmd({OP_ERASE_4K, 24'h010000}, 4);
        chk(req_cnt, n);
        cmd({OP_ERASE_8K, 24'h000000}, 4);
        chk(req_cnt, n);
        cmd({OP_WRITE_REGS, 8'h00, 8'h04, 8'h00}, 3);
        chk(first_config_register, 8'h04);
        cmd({OP_ERASE_4K, 24'hfff000}, 4);
        chk_op(n, SEPC_KIND_ERASE_4K, 32'h00fff000);
        n = req_cnt;
        cmd({OP_ERASE_BIG, 24'hff0000}, 4);
        chk_op(n, SEPC_KIND_ERASE_64K, 32'h00ff0000);
        uniform_256k <= 1'b1;
        rdreg(OP_READ_SR2, v);
        chk(v, 8'h80);
        chk(so_oe, 1'b0);
        n = req_cnt;
        cmd({OP_ERASE_4K, 24'hfff000}, 4);
        chk(req_cnt, n);
        cmd({OP_ERASE_BIG, 24'h040000}, 4);
        chk_op(n, SEPC_KIND_ERASE_256K, 32'h00040000);
        uniform_256k <= 1'b0;
        op_fail <= 1'b1;
        cmd({OP_ERASE_BIG, 24'h000000}, 4);
        chk(status_reg, 8'h20);
        op_fail <= 1'b0;
        cmd({OP_BANK_WRITE, 8'h00, 16'h0000}, 2);
        chk(status_reg, 8'h20);
        cmd({OP_CLEAR_STATUS, 24'h000000}, 1);
        chk(status_reg, 8'h00);
        cmd({OP_WRITE_REGS, 8'h1c, 8'h04, 8'h00}, 3);
        n = req_cnt;
        cmd({OP_PROGRAM, 24'h000100}, 4);
        cmd({OP_ERASE_BIG, 24'h000000}, 4);
        chk(req_cnt, n);
        chk(status_reg, 8'h7c);
        cmd({OP_CLEAR_STATUS, 24'h000000}, 1);
        cmd({OP_WRITE_REGS, 8'h00, 8'h25, 8'h00}, 3);
        chk({otp_locked, first_config_register}, 9'h125);
        cmd({OP_WRITE_REGS, 8'h1c, 8'h00, 8'h00}, 3);
        chk(status_reg, 8'h00);
        chk(first_config_register, 8'h25);
        line_three_is_reset <= 1'b1;
        quad_line_three <= 1'b0;
        repeat (10) @(posedge mclk);
        quad_line_three <= 1'b1;
        repeat (10) @(posedge mclk);
        chk(first_config_register, 8'h00);
        test_done();
    end
endmodule

bind sepc_top sepc_chk u_chk (.mclk(mclk), .nrst(nrst), .cs_n(cs_n), .line_three_is_reset(line_three_is_reset),
    .uniform_256k(uniform_256k), .op(op), .op_done(op_done), .op_fail(op_fail), .status_reg(status_reg),
    .first_config_register(first_config_register), .second_status_register(second_status_register),
    .bank_reg(bank_reg), .otp_locked(otp_locked));
`default_nettype wire
